// >>> logic/gnc_unit.sv
module gnc_unit #(
   parameter bit         EXTENDED           = 1'b0,  // Extended fine gain variant
   parameter logic [7:0] CHARGE_SENS_TENTHS = 8'h0a  // Factory charge amp, 1.0 mV/pC
) (
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                cmdValid,       // Command strobe
   input  wire gnc_pkg::gnc_op_t    cmdOp,          // Command code
   input  wire logic [4:0]          cmdChan,        // Channel 0..16
   input  wire logic [15:0]         cmdValue,       // Argument
   input  wire logic                cmdMenu,        // Issued from front panel
   input  wire logic                normFitted,     // Normalize feature installed
   output logic                     cmdReady,       // Idle, command may be given
   output logic                     rspValid,       // Answer strobe
   output gnc_pkg::gnc_rsp_t        rspCode,        // Answer kind
   output logic [4:0]               rspChan,        // Channel reported
   output logic [15:0]              rspSens,        // Sensitivity, 0.1 mV/unit
   output logic [3:0]               rspLevel,       // Output level, volts
   output logic [15:0]              rspExpect,      // Expected input, units
   output logic                     rspChargeUnit,  // Label pC/unit
   output logic                     gainWrValid,    // Gain update strobe
   output logic [3:0]               gainWrChan,     // Channel index 0..15
   output logic [23:0]              gainWrValue     // New gain code
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Channel numbers one to sixteen only
   function automatic logic chanOk(input logic [4:0] ch);
      chanOk = (ch != 5'h00) && (ch <= 5'h10);
   endfunction : chanOk

   // Gain code inside the fitted gain stage's limits
   function automatic logic gainOk(input logic [39:0] g);
      if (EXTENDED) begin
         gainOk = (g >= gnc_pkg::GMIN_EXT) && (g <= gnc_pkg::GMAX_EXT);
      end else begin
         gainOk = (g >= gnc_pkg::GMIN_STD) && (g <= gnc_pkg::GMAX_STD);
      end
   endfunction : gainOk

   typedef enum {ST_IDLE, ST_LOAD, ST_DIV, ST_CHECK, ST_COMMIT} gnc_state_t;

   localparam logic [39:0] NUMK     = EXTENDED ? gnc_pkg::NUMK_EXT : gnc_pkg::NUMK_STD;
   localparam logic [23:0] GAIN_RST = EXTENDED ? gnc_pkg::GAIN_RST_EXT
                                               : gnc_pkg::GAIN_RST_STD;

   // ****************************************************************
   // State
   // ****************************************************************
   gnc_state_t          state_q;             // Sequencer
   logic [15:0]         sens_q   [16];       // Sensitivity per channel
   logic [15:0]         expect_q [16];       // Expected input per channel
   gnc_pkg::gnc_mode_t  mode_q   [16];       // Input mode per channel
   logic [23:0]         gain_q   [16];       // Committed gain codes
   logic [23:0]         tmp_q    [16];       // Candidate gains before commit
   logic [3:0]          level_q;             // Rack output level
   logic [3:0]          levelCand_q;         // Level under trial
   logic [15:0]         sensCand_q;          // Sensitivity under trial
   logic [15:0]         expCand_q;           // Expected input under trial
   logic                trySens_q;           // Trial changes sensitivity
   logic                tryExp_q;            // Trial changes expected input
   logic                tryMenu_q;           // Trial came from the panel
   logic [4:0]          tgtChan_q;           // Channel named by command
   logic [3:0]          first_q;             // First channel of trial
   logic [3:0]          last_q;              // Last channel of trial
   logic [3:0]          cur_q;               // Channel being computed
   logic [39:0]         num_q;               // Dividend, shifted out msb first
   logic [39:0]         div_q;               // Divisor
   logic [40:0]         rem_q;               // Partial remainder
   logic [39:0]         quo_q;               // Quotient, gain code
   logic [5:0]          step_q;              // Divider step

   // ****************************************************************
   // Decode of the incoming command
   // ****************************************************************
   wire logic [3:0]  cmdIdx    = cmdChan[3:0] - 4'h1;          // 0-based channel
   wire logic        cmdChanOk = chanOk(cmdChan);
   wire logic        isMenuOp  = (cmdOp == gnc_pkg::OP_MENU_SENS) ||
                                 (cmdOp == gnc_pkg::OP_MENU_LEVEL) ||
                                 (cmdOp == gnc_pkg::OP_MENU_EXP) ||
                                 (cmdOp == gnc_pkg::OP_LEVEL_UP) ||
                                 (cmdOp == gnc_pkg::OP_LEVEL_DOWN);
   wire logic        isQuery   = (cmdOp == gnc_pkg::OP_QRY_SENS) ||
                                 (cmdOp == gnc_pkg::OP_QRY_EXP);
   wire logic        isRackSet = (cmdOp == gnc_pkg::OP_SET_SENS) &&
                                 (cmdChan == 5'h00);
   wire logic        isStep    = (cmdOp == gnc_pkg::OP_LEVEL_UP) ||
                                 (cmdOp == gnc_pkg::OP_LEVEL_DOWN);
   wire logic        isChanSet = ((cmdOp == gnc_pkg::OP_SET_SENS) && !isRackSet) ||
                                 (cmdOp == gnc_pkg::OP_SET_EXP);

   // Level steps wrap at both ends
   wire logic [3:0]  levelUp   = (level_q >= gnc_pkg::LEVEL_MAX) ? gnc_pkg::LEVEL_MIN
                                 : level_q + 4'h1;
   wire logic [3:0]  levelDn   = (level_q <= gnc_pkg::LEVEL_MIN) ? gnc_pkg::LEVEL_MAX
                                 : level_q - 4'h1;
   wire logic [3:0]  levelReq  = isStep ? ((cmdOp == gnc_pkg::OP_LEVEL_UP) ? levelUp
                                 : levelDn) : cmdValue[3:0];
   wire logic        levelLegal = (cmdValue <= 16'h000a) && (cmdValue != 16'h0000);

   // Panel menus open on channel 1, queries on the named channel
   wire logic [3:0]  infoIdx   = isMenuOp ? 4'h0 : cmdIdx;
   wire logic [4:0]  infoChan  = {1'b0, infoIdx} + 5'h01;

   // ****************************************************************
   // Divider operands for the channel under trial
   // ****************************************************************
   wire logic        curIsTgt  = ({1'b0, cur_q} + 5'h01) == tgtChan_q;
   wire logic [15:0] sensEff   = (curIsTgt && trySens_q) ? sensCand_q : sens_q[cur_q];
   wire logic [15:0] expEff    = (curIsTgt && tryExp_q) ? expCand_q : expect_q[cur_q];
   // Powered and voltage inputs share one formula; charge adds the amp
   wire logic [7:0]  factor    = (mode_q[cur_q] == gnc_pkg::MODE_CHARGE) ?
                                 CHARGE_SENS_TENTHS : gnc_pkg::POWERED_FACTOR;
   wire logic [39:0] divisor   = 40'(sensEff) * 40'(expEff) * 40'(factor);
   wire logic [39:0] numer     = NUMK * 40'(levelCand_q);
   wire logic [40:0] trial     = {rem_q[39:0], num_q[39]};
   wire logic        fits      = trial >= {1'b0, div_q};
   // Zero sensitivity or expected value can never give a legal gain
   wire logic        legal     = (div_q != 40'h0) && gainOk(quo_q);
   wire logic        same      = tryMenu_q && trySens_q && curIsTgt &&
                                 (quo_q[23:0] == gain_q[cur_q]);

   // ****************************************************************
   // Sequencer: decode, trial division per channel, commit
   // ****************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q       <= ST_IDLE;
         for (int i = 0; i < 16; i++) begin
            sens_q[i]   <= gnc_pkg::SENS_RST;
            expect_q[i] <= gnc_pkg::EXPECT_RST;
            mode_q[i]   <= gnc_pkg::MODE_POWERED;
            gain_q[i]   <= GAIN_RST;
            tmp_q[i]    <= GAIN_RST;
         end
         level_q       <= gnc_pkg::LEVEL_RST;
         levelCand_q   <= gnc_pkg::LEVEL_RST;
         sensCand_q    <= gnc_pkg::SENS_RST;
         expCand_q     <= gnc_pkg::EXPECT_RST;
         trySens_q     <= 1'b0;
         tryExp_q      <= 1'b0;
         tryMenu_q     <= 1'b0;
         tgtChan_q     <= 5'h00;
         first_q       <= 4'h0;
         last_q        <= 4'h0;
         cur_q         <= 4'h0;
         num_q         <= 40'h0;
         div_q         <= 40'h0;
         rem_q         <= 41'h0;
         quo_q         <= 40'h0;
         step_q        <= 6'h00;
         cmdReady      <= 1'b0;
         rspValid      <= 1'b0;
         rspCode       <= gnc_pkg::RSP_OK;
         rspChan       <= 5'h00;
         rspSens       <= 16'h0000;
         rspLevel      <= 4'h0;
         rspExpect     <= 16'h0000;
         rspChargeUnit <= 1'b0;
         gainWrValid   <= 1'b0;
         gainWrChan    <= 4'h0;
         gainWrValue   <= 24'h000000;
      end else begin
         rspValid    <= 1'b0;
         gainWrValid <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               cmdReady <= 1'b1;
               // Answer fields default to the addressed channel
               rspChan       <= infoChan;
               rspSens       <= sens_q[infoIdx];
               rspLevel      <= level_q;
               rspExpect     <= expect_q[infoIdx];
               rspChargeUnit <= (mode_q[infoIdx] == gnc_pkg::MODE_CHARGE);
               tryMenu_q     <= cmdMenu;
               if (cmdValid) begin
                  if (isMenuOp && !normFitted) begin
                     // Panel menus refuse when the feature is missing
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_ABSENT;
                  end else if (isQuery && !cmdChanOk) begin
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_CHAN;
                  end else if (isQuery || (isMenuOp && !isStep)) begin
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_INFO;
                  end else if (cmdOp == gnc_pkg::OP_SET_MODE) begin
                     rspValid <= 1'b1;
                     if (!cmdChanOk || (cmdValue[1:0] == 2'h3)) begin
                        rspCode <= cmdChanOk ? gnc_pkg::RSP_VALUE : gnc_pkg::RSP_CHAN;
                     end else begin
                        // Mode takes effect at the next gain calculation
                        mode_q[cmdIdx] <= gnc_pkg::gnc_mode_t'(cmdValue[1:0]);
                        rspCode        <= gnc_pkg::RSP_OK;
                     end
                  end else if (isRackSet && !levelLegal) begin
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_VALUE;
                  end else if (isRackSet || isStep) begin
                     // Level change retries every channel before any update
                     levelCand_q <= levelReq;
                     sensCand_q  <= sens_q[0];
                     expCand_q   <= expect_q[0];
                     trySens_q   <= 1'b0;
                     tryExp_q    <= 1'b0;
                     tgtChan_q   <= 5'h00;
                     first_q     <= 4'h0;
                     last_q      <= 4'hf;
                     cur_q       <= 4'h0;
                     cmdReady    <= 1'b0;
                     state_q     <= ST_LOAD;
                  end else if (isChanSet && !cmdChanOk) begin
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_CHAN;
                  end else if (isChanSet) begin
                     // Only the named channel is recomputed
                     levelCand_q <= level_q;
                     sensCand_q  <= (cmdOp == gnc_pkg::OP_SET_SENS) ?
                                    cmdValue : sens_q[cmdIdx];
                     expCand_q   <= (cmdOp == gnc_pkg::OP_SET_EXP) ?
                                    cmdValue : expect_q[cmdIdx];
                     trySens_q   <= (cmdOp == gnc_pkg::OP_SET_SENS);
                     tryExp_q    <= (cmdOp == gnc_pkg::OP_SET_EXP);
                     tgtChan_q   <= cmdChan;
                     first_q     <= cmdIdx;
                     last_q      <= cmdIdx;
                     cur_q       <= cmdIdx;
                     cmdReady    <= 1'b0;
                     state_q     <= ST_LOAD;
                  end else begin
                     // Unknown code: refused, nothing stored
                     rspValid <= 1'b1;
                     rspCode  <= gnc_pkg::RSP_VALUE;
                  end
               end
            end
            ST_LOAD: begin
               num_q   <= numer;
               div_q   <= divisor;
               rem_q   <= 41'h0;
               quo_q   <= 40'h0;
               step_q  <= 6'h00;
               state_q <= ST_DIV;
            end
            ST_DIV: begin
               // Restoring division, one quotient bit a cycle; slow but small
               rem_q   <= fits ? (trial - {1'b0, div_q}) : trial;
               quo_q   <= {quo_q[38:0], fits};
               num_q   <= {num_q[38:0], 1'b0};
               step_q  <= step_q + 6'h01;
               if (step_q == gnc_pkg::DIV_LAST) begin
                  state_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               rspChan       <= tgtChan_q;
               rspSens       <= sensCand_q;
               rspLevel      <= levelCand_q;
               rspExpect     <= expCand_q;
               rspChargeUnit <= (mode_q[cur_q] == gnc_pkg::MODE_CHARGE);
               if (!legal || same) begin
                  // Abandon the whole trial; committed values untouched
                  rspValid <= 1'b1;
                  rspCode  <= legal ? gnc_pkg::RSP_SAME : gnc_pkg::RSP_RANGE;
                  state_q  <= ST_IDLE;
               end else begin
                  tmp_q[cur_q] <= quo_q[23:0];
                  if (cur_q == last_q) begin
                     cur_q   <= first_q;
                     state_q <= ST_COMMIT;
                  end else begin
                     cur_q   <= cur_q + 4'h1;
                     state_q <= ST_LOAD;
                  end
               end
            end
            ST_COMMIT: begin
               // One gain update per cycle to the gain stages
               gain_q[cur_q] <= tmp_q[cur_q];
               gainWrValid   <= 1'b1;
               gainWrChan    <= cur_q;
               gainWrValue   <= tmp_q[cur_q];
               if (cur_q == last_q) begin
                  level_q  <= levelCand_q;
                  if (trySens_q) begin
                     sens_q[tgtChan_q[3:0] - 4'h1] <= sensCand_q;
                  end
                  if (tryExp_q) begin
                     expect_q[tgtChan_q[3:0] - 4'h1] <= expCand_q;
                  end
                  rspValid <= 1'b1;
                  rspCode  <= gnc_pkg::RSP_OK;
                  state_q  <= ST_IDLE;
               end else begin
                  cur_q <= cur_q + 4'h1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule : gnc_unit

// >>> logic/gnc_pkg.sv
package gnc_pkg;

   // ****************************************************************
   // Widths and counts
   // ****************************************************************
   localparam int NUM_CHAN   = 16;          // Channels per rack
   localparam int DIV_W      = 40;          // Divider width
   localparam int GAIN_W     = 24;          // Stored gain code width
   localparam logic [5:0] DIV_LAST = 6'h27; // Last divider step

   // ****************************************************************
   // Values after reset, level limits and powered factor
   // ****************************************************************
   localparam logic [15:0] SENS_RST   = 16'h2710; // 1000.0 mV/unit, tenths
   localparam logic [3:0]  LEVEL_RST  = 4'h1;     // 1 V/unit
   localparam logic [15:0] EXPECT_RST = 16'h0001; // 1 unit
   localparam logic [3:0]  LEVEL_MIN  = 4'h1;     // Lowest level, volts
   localparam logic [3:0]  LEVEL_MAX  = 4'ha;     // Highest level, volts
   localparam logic [7:0]  POWERED_FACTOR = 8'h0a; // Tenths-to-units factor

   // ****************************************************************
   // Gain scaling: standard codes are gain*10, extended gain*10000
   // ****************************************************************
   localparam logic [39:0] NUMK_STD  = 40'h00_000f_4240; // 1e6
   localparam logic [39:0] NUMK_EXT  = 40'h00_3b9a_ca00; // 1e9
   localparam logic [39:0] GMIN_STD  = 40'h00_0000_0001; // 0.1
   localparam logic [39:0] GMAX_STD  = 40'h00_0000_07d0; // 200
   localparam logic [39:0] GMIN_EXT  = 40'h00_0000_0019; // 0.0025
   localparam logic [39:0] GMAX_EXT  = 40'h00_001e_8480; // 200
   localparam logic [23:0] GAIN_RST_STD = 24'h00000a;    // Gain 1
   localparam logic [23:0] GAIN_RST_EXT = 24'h002710;    // Gain 1

   // ****************************************************************
   // Commands, answers and modes
   // ****************************************************************
   typedef enum logic [3:0] {
      OP_SET_SENS, OP_QRY_SENS, OP_SET_EXP, OP_QRY_EXP, OP_SET_MODE,
      OP_MENU_SENS, OP_MENU_LEVEL, OP_MENU_EXP, OP_LEVEL_UP, OP_LEVEL_DOWN
   } gnc_op_t;

   typedef enum logic [2:0] {
      RSP_OK, RSP_RANGE, RSP_CHAN, RSP_VALUE, RSP_INFO, RSP_ABSENT, RSP_SAME
   } gnc_rsp_t;

   typedef enum logic [1:0] {
      MODE_POWERED, MODE_VOLTAGE, MODE_CHARGE
   } gnc_mode_t;

endpackage : gnc_pkg

// >>> bench/gnc_unit_asserts.sv
module gnc_unit_asserts #(
   parameter bit EXTENDED = 1'b0  // Fine gain variant in use
) (
   input wire logic              mclk,
   input wire logic              reset,
   input wire logic              cmdValid,
   input wire gnc_pkg::gnc_op_t  cmdOp,
   input wire logic [4:0]        cmdChan,
   input wire logic [15:0]       cmdValue,
   input wire logic              cmdMenu,
   input wire logic              normFitted,
   input wire logic              cmdReady,
   input wire logic              rspValid,
   input wire gnc_pkg::gnc_rsp_t rspCode,
   input wire logic [4:0]        rspChan,
   input wire logic [15:0]       rspSens,
   input wire logic [3:0]        rspLevel,
   input wire logic [15:0]       rspExpect,
   input wire logic              rspChargeUnit,
   input wire logic              gainWrValid,
   input wire logic [3:0]        gainWrChan,
   input wire logic [23:0]       gainWrValue
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Shared terms
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   localparam logic [23:0] G_MIN = EXTENDED ? 24'h000019 : 24'h000001; // Lowest code
   localparam logic [23:0] G_MAX = EXTENDED ? 24'h1e8480 : 24'h0007d0; // Highest code
   wire logic cmdTaken  = cmdValid && cmdReady;                 // Command accepted
   wire logic chanOk    = cmdChan >= 5'h01 && cmdChan <= 5'h10; // Channel 1..16
   wire logic gainLegal = gainWrValue >= G_MIN && gainWrValue <= G_MAX; // Code in limits
   wire logic rangeRsp  = rspValid && rspCode == gnc_pkg::RSP_RANGE;    // Range refusal
   wire logic qryOp     = cmdOp inside {gnc_pkg::OP_QRY_SENS, gnc_pkg::OP_QRY_EXP};
   wire logic setExpOp  = cmdOp == gnc_pkg::OP_SET_EXP;          // Expected-input write
   wire logic menuSens  = cmdOp == gnc_pkg::OP_MENU_SENS;        // Sensitivity menu entry
   wire logic menuEntry = cmdOp inside {gnc_pkg::OP_MENU_SENS, gnc_pkg::OP_MENU_LEVEL,
                                        gnc_pkg::OP_MENU_EXP};
   // Rack level of zero or above ten volts
   wire logic badLevel  = cmdOp == gnc_pkg::OP_SET_SENS && cmdChan == 5'h00 &&
                          (cmdValue == 16'h0000 || cmdValue > 16'h000a);
   // Multi-step answer: writes first, then the accept answer
   sequence okAnswer;
      rspValid && rspCode == gnc_pkg::RSP_OK;
   endsequence
   // Last write shares its cycle with the answer; sixteen writes span 15 more
   chk_write_then_ok: assert property (gainWrValid |-> ##[0:15] okAnswer)
      else $error("gain write without accept answer");
   chk_gain_limits: assert property (gainWrValid |-> gainLegal)
      else $error("gain write outside limits");
   chk_range_no_write: assert property (rangeRsp |-> !gainWrValid && !$past(gainWrValid))
      else $error("gain written on range error");
   chk_query_info: assert property (cmdTaken && chanOk && qryOp |=>
      rspValid && rspCode == gnc_pkg::RSP_INFO && rspChan == $past(cmdChan))
      else $error("query answer wrong");
   chk_bad_chan: assert property (cmdTaken && !chanOk && setExpOp |=>
      rspValid && rspCode == gnc_pkg::RSP_CHAN && !gainWrValid)
      else $error("bad channel not refused");
   chk_level_value: assert property (cmdTaken && badLevel |=>
      rspValid && rspCode == gnc_pkg::RSP_VALUE)
      else $error("illegal level not refused");
   chk_menu_absent: assert property (cmdTaken && !normFitted && menuEntry |=>
      rspValid && rspCode == gnc_pkg::RSP_ABSENT)
      else $error("menu opened without feature");
   chk_menu_chan1: assert property (cmdTaken && normFitted && menuSens |=>
      rspValid && rspChan == 5'h01)
      else $error("sensitivity menu not on channel 1");
   chk_busy_bounded: assert property ($fell(cmdReady) |-> ##[1:700] rspValid)
      else $error("calculation never answered");
   chk_ready_returns: assert property (rspValid && !cmdReady |-> ##[0:1] cmdReady)
      else $error("ready not back after answer");
endmodule : gnc_unit_asserts

// >>> bench/gnc_host_model.sv
module gnc_host_model (
   input  wire logic       mclk,
   input  wire logic       cmdReady,
   output logic            cmdValid,
   output gnc_pkg::gnc_op_t cmdOp,
   output logic [4:0]      cmdChan,
   output logic [15:0]     cmdValue,
   output logic            cmdMenu
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      {cmdValid, cmdChan, cmdValue, cmdMenu} = '0;
      cmdOp = gnc_pkg::OP_QRY_SENS;
   end
   // One command, held until the taking edge; channel and value passed on unchecked
   task automatic send(input int op, input int ch, input int v, input int m);
      @(posedge mclk);
      while (cmdReady !== 1'b1) @(posedge mclk);
      cmdValid <= 1'b1;
      cmdOp    <= gnc_pkg::gnc_op_t'(op);
      cmdChan  <= 5'(ch);
      cmdValue <= 16'(v);
      cmdMenu  <= 1'(m);
      @(posedge mclk);
      cmdValid <= 1'b0;
      // Released fields show junk, so a design latching late is caught
      {cmdChan, cmdValue} <= ~{cmdChan, cmdValue};
   endtask : send
endmodule : gnc_host_model

// >>> bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int op, ch, v, m, code, wch, gain;} gnc_row_t; // wch 0: no write
   logic mclk, reset, normFitted, cmdValid, cmdMenu, cmdReady, rspValid, rspChargeUnit;
   logic gainWrValid;
   gnc_pkg::gnc_op_t  cmdOp;
   gnc_pkg::gnc_rsp_t rspCode;
   logic [4:0]  cmdChan, rspChan;
   logic [15:0] cmdValue, rspSens, rspExpect;
   logic [3:0]  rspLevel, gainWrChan;
   logic [23:0] gainWrValue;
   int badCount, checksDone;
   // Ordinary cases; charge amp 2.0 mV/pC, gain code = gain*10, truncated
   gnc_row_t rows[26] = '{
      '{1,3,0,0,4,0,0}, '{0,6,112,0,0,6,892}, '{0,6,40,0,1,0,0},
      '{0,17,100,0,2,0,0}, '{2,0,5,0,2,0,0}, '{2,6,2,0,0,6,446},
      '{4,6,1,0,0,0,0}, '{0,6,224,0,0,6,223}, '{4,6,2,0,0,0,0},
      '{0,6,224,0,0,6,111}, '{4,6,3,0,3,0,0}, '{0,0,11,0,3,0,0},
      '{0,0,0,0,3,0,0}, '{0,0,2,0,0,6,223}, '{2,1,20,0,0,1,1},
      '{0,0,1,0,1,0,0}, '{0,0,10,0,0,1,5}, '{2,1,1,0,0,1,100},
      '{6,1,0,1,4,0,0}, '{8,1,0,1,0,1,10}, '{9,1,0,1,0,1,100},
      '{0,2,10000,1,6,0,0}, '{0,2,40,1,1,0,0}, '{2,2,200,1,1,0,0},
      '{5,1,0,1,4,0,0}, '{7,1,0,1,4,0,0}};

   gnc_unit #(.CHARGE_SENS_TENTHS(8'h14)) u_gnc_unit (.mclk, .reset, .cmdValid, .cmdOp, .cmdChan,
      .cmdValue, .cmdMenu, .normFitted, .cmdReady, .rspValid, .rspCode, .rspChan, .rspSens,
      .rspLevel, .rspExpect, .rspChargeUnit, .gainWrValid, .gainWrChan, .gainWrValue);
   gnc_host_model u_gnc_host_model (.mclk, .cmdReady, .cmdValid, .cmdOp, .cmdChan, .cmdValue,
      .cmdMenu);

   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // One compare, counted
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Issue a row and wait, bounded, for its answer and gain write
   task automatic run(input gnc_row_t r);
      bit seen, wrote;
      seen = 1'b0;
      wrote = 1'b0;
      u_gnc_host_model.send(r.op, r.ch, r.v, r.m);
      for (int n = 0; n < 1000 && !seen; n++) begin
         @(negedge mclk);
         if (gainWrValid === 1'b1 && r.wch != 0 && gainWrChan === 4'(r.wch - 1)) begin
            wrote = 1'b1;
            chk(32'(gainWrValue), r.gain);
         end else if (gainWrValid === 1'b1 && r.wch == 0) begin
            chk(32'h1, 32'h0);
         end
         seen = (rspValid === 1'b1);
      end
      chk(32'(seen), 32'h1);
      chk(32'(rspCode), r.code);
      if (r.wch != 0) chk(32'(wrote), 32'h1);
   endtask : run
   // Single exit with verdict
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finishTest
   // Hang guard, about nine times the expected run
   initial begin
      repeat (30000) @(posedge mclk);
      badCount++;
      finishTest();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      reset = 1'b1;
      normFitted = 1'b1;
      badCount = 0;
      checksDone = 0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      foreach (rows[i]) run(rows[i]);
      run('{4,1,2,0,0,0,0});
      run('{5,1,0,1,4,0,0});
      chk(32'(rspChargeUnit), 32'h1);
      run('{3,1,0,0,4,0,0});
      chk(32'(rspExpect), 32'h1);
      chk(32'(rspLevel), 32'ha);
      @(posedge mclk);
      normFitted <= 1'b0;
      run('{6,1,0,1,5,0,0});
      @(posedge mclk);
      reset <= 1'b1;
      normFitted <= 1'b1;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      run('{3,6,0,0,4,0,0});
      chk(32'(rspSens), 32'h2710);
      chk(32'(rspLevel), 32'h1);
      chk(32'(rspExpect), 32'h1);
      finishTest();
   end
endmodule : tb

bind gnc_unit gnc_unit_asserts #(.EXTENDED(EXTENDED)) u_gnc_unit_asserts (.mclk, .reset,
   .cmdValid, .cmdOp, .cmdChan, .cmdValue, .cmdMenu, .normFitted, .cmdReady, .rspValid,
   .rspCode, .rspChan, .rspSens, .rspLevel, .rspExpect, .rspChargeUnit, .gainWrValid,
   .gainWrChan, .gainWrValue);
